// ---- asr_ctrl.sv ----
// readout control: self-test timing, locked output registers, boot pins
`timescale 1ns/1ps
`default_nettype none
`include "asr_regs.svh"
module asr_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int ST_BASE_CYC =
    int'($ceil(`ASR_ST_BASE_US * 1000.0 / `ASR_CLK_NS)),
  parameter int ODR_BASE_CYC =
    int'($ceil(`ASR_ODR_BASE_US * 1000.0 / `ASR_CLK_NS)),
  parameter int BOOT_CYC =
    int'($ceil(`ASR_BOOT_US * 1000.0 / `ASR_CLK_NS)),
  parameter int PULSE2_CYC =
    int'($ceil(`ASR_PULSE2_MS * 1.0e6 / `ASR_CLK_NS))
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic external_sample_trigger,
  input wire logic boot_config_pin,
  input wire logic motion_detect_pin_i,
  output logic motion_detect_pin_o,
  output logic motion_detect_pin_oe,
  input wire logic motion_event,
  output logic irq_pin_one_o,
  output logic irq_pin_one_oe,
  output logic irq_pin_two_o,
  output logic irq_pin_two_oe,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [43:0] smp_data,
  output logic meas_req,
  output logic selftest_active,
  output logic [1:0] power_mode,
  output logic [3:0] odr_code,
  output logic hibernate
);
  localparam int ST_STEP_CYC =
    int'($ceil(`ASR_ST_STEP_US * 1000.0 / `ASR_CLK_NS));
  localparam int PULSE1_CYC =
    int'($ceil(`ASR_PULSE1_US * 1000.0 / `ASR_CLK_NS));
  asr_pkg::asr_ctrl_s s;
  asr_pkg::asr_ctrl_s next_s;
  logic busy;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic fifo_valid;
  logic [43:0] fifo_data;
  logic pop;
  logic [3:0] eff_dec;
  logic [19:0] unit_len;
  logic [12:0] rep_target;
  logic boot_on;
  logic strap_now;
  logic irq_pin_one_act;
  logic irq_pin_two_act;
  logic od;
  logic soft_rst;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sum of absolute axis values, saturated so it never wraps
  function automatic logic [11:0] vmag(input logic [35:0] v);
    logic [13:0] acc;
    logic [11:0] mag;
    acc = '0;
    mag = '0;
    for (int i = 0; i < 3; i++) begin
      // negate at 12 bits, a wider negation would wrap the magnitude
      mag = v[i*12+11] ? -v[i*12 +: 12] : v[i*12 +: 12];
      acc = acc + 14'(mag);
    end
    return (acc > 14'(`ASR_VM_MAX)) ? `ASR_VM_MAX : acc[11:0];
  endfunction

  // byte view of a 12-bit value, high byte zero-filled
  function automatic logic [7:0] byte_of(input logic [11:0] v,
                                         input logic hi);
    return hi ? {4'h0, v[11:8]} : v[7:0];
  endfunction

  // ----------------------------------------
  // register port and shadow fifo
  // ----------------------------------------
  asr_spi_slave u_spi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe),
    .busy(busy),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata)
  );

  // the fifo drains only while no transaction holds the outputs
  asr_fifo #(.WIDTH(44), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(fifo_valid),
    .out_ready(~busy),
    .out_data(fifo_data)
  );
  assign pop = fifo_valid & ~busy;
  assign soft_rst = wr_stb && addr == `ASR_A_CTRL1 &&
                    wdata[`ASR_CTRL1_RST];

  // ----------------------------------------
  // self-test timing terms
  // ----------------------------------------
  assign eff_dec = (s.selfcheck_sample_count > `ASR_SELFCHECK_SAMPLE_COUNT_MAX) ? `ASR_SELFCHECK_SAMPLE_COUNT_MAX
                                                : s.selfcheck_sample_count;
  assign rep_target = 13'h0001 << eff_dec;
  assign unit_len = 20'(ST_BASE_CYC + int'(s.selfcheck_idle_len) * ST_STEP_CYC);

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always_comb begin
    logic [6:0] off;
    off = 7'h00;
    rdata = 8'h00;
    if (addr >= `ASR_A_OUT && addr < `ASR_A_OUT + 7'h06) begin
      off = addr - `ASR_A_OUT;
      rdata = byte_of(s.out[2'h2 - off[2:1]], off[0]);
    end else if (addr >= `ASR_A_BUF && addr < `ASR_A_BUF + 7'h06) begin
      off = addr - `ASR_A_BUF;
      rdata = byte_of(s.bufd[2'h2 - off[2:1]], off[0]);
    end else if (addr == `ASR_A_VM || addr == `ASR_A_VM + 7'h01) begin
      rdata = byte_of(s.vm, addr[0]);
    end else begin
      unique case (addr)
        `ASR_A_STATUS: begin
          rdata[`ASR_STAT_DRDY] = s.drdy;
          rdata[`ASR_STAT_BOOT] = (s.boot != asr_pkg::boot_wait);
        end
        `ASR_A_TEMP: rdata = s.temp;
        `ASR_A_CTRL1: rdata = s.ctrl1;
        `ASR_A_ODR: rdata = {4'h0, s.odr};
        `ASR_A_INT_EN: rdata = {7'h00, s.boot_pulse_disable};
        `ASR_A_PIN_SEL: rdata = {6'h00, s.pin_sel};
        `ASR_A_MOT_CFG: rdata = s.mot_cfg;
        `ASR_A_SELFCHECK_IDLE_LEN: rdata = {3'h0, s.selfcheck_idle_len};
        `ASR_A_SELFCHECK_SAMPLE_COUNT: rdata = {4'h0, s.selfcheck_sample_count};
        default: rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.meas_req = 1'b0;
    next_s.trig_sync = {s.trig_sync[0], external_sample_trigger};
    next_s.trig_prev = s.trig_sync[1];
    next_s.strap_sync = {s.strap_sync[0], boot_config_pin};
    next_s.mot_sync = {s.mot_sync[0], motion_detect_pin_i};
    next_s.mot_prev = s.mot_sync[1];
    next_s.busy_prev = busy;
    // boot sequence; the strap is caught as boot ends
    unique case (s.boot)
      asr_pkg::boot_wait: begin
        next_s.boot_cnt = s.boot_cnt + 32'h0000_0001;
        if (s.boot_cnt == 32'(BOOT_CYC - 1)) begin
          next_s.boot = asr_pkg::boot_pulse;
          next_s.boot_cnt = '0;
          next_s.strap = s.strap_sync[1];
          if (s.strap_sync[1]) begin
            next_s.mot_cfg = `ASR_MOT_DEFAULT;
          end
        end
      end
      asr_pkg::boot_pulse: begin
        next_s.boot_cnt = s.boot_cnt + 32'h0000_0001;
        if (s.boot_cnt == (s.strap ? 32'(PULSE2_CYC - 1)
                                   : 32'(PULSE1_CYC - 1))) begin
          next_s.boot = asr_pkg::boot_run;
        end
      end
      asr_pkg::boot_run: begin
      end
    endcase
    // register writes
    if (wr_stb) begin
      unique case (addr)
        `ASR_A_CTRL1: begin
          next_s.ctrl1 = wdata;
          next_s.ctrl1[`ASR_CTRL1_RST] = 1'b0;
          if (wdata[`ASR_CTRL1_HIB]) begin
            next_s.hib = 1'b1;
          end
        end
        `ASR_A_ODR: next_s.odr = wdata[3:0];
        `ASR_A_INT_EN: next_s.boot_pulse_disable = wdata[0];
        `ASR_A_PIN_SEL: next_s.pin_sel = wdata[1:0];
        `ASR_A_MOT_CFG: next_s.mot_cfg = wdata;
        `ASR_A_SELFCHECK_IDLE_LEN: next_s.selfcheck_idle_len = wdata[4:0];
        `ASR_A_SELFCHECK_SAMPLE_COUNT: next_s.selfcheck_sample_count = wdata[3:0];
        default: begin
        end
      endcase
    end
    // hibernate: the motion pin steers it in strap-high mode
    if (s.strap && !s.mot_sync[1] && s.mot_prev) begin
      next_s.hib = 1'b1;
    end
    if ((busy && !s.busy_prev) ||
        (s.strap && s.mot_sync[1] && !s.mot_prev)) begin
      next_s.hib = 1'b0;
    end
    // reading status clears data-ready; a new sample wins the tie
    if (rd_stb && addr == `ASR_A_STATUS) begin
      next_s.drdy = 1'b0;
    end
    if (pop) begin
      next_s.bufd = s.out;
      next_s.out = fifo_data[43:8];
      next_s.temp = fifo_data[7:0];
      next_s.vm = vmag(fifo_data[43:8]);
      next_s.drdy = 1'b1;
    end
    // self-test measurement timer overrides the user rate
    if (s.ctrl1[`ASR_CTRL1_AXIS] == `ASR_AXIS_OFF || s.hib) begin
      next_s.st_active = 1'b0;
      next_s.unit_cnt = '0;
      next_s.rep_cnt = '0;
    end else if (!s.st_active) begin
      next_s.st_active = 1'b1;
      next_s.unit_cnt = unit_len - 20'h0_0001;
      next_s.rep_cnt = '0;
    end else if (s.unit_cnt != '0) begin
      next_s.unit_cnt = s.unit_cnt - 20'h0_0001;
    end else begin
      next_s.unit_cnt = unit_len - 20'h0_0001;
      next_s.rep_cnt = s.rep_cnt + 13'h0001;
      if (s.rep_cnt >= rep_target - 13'h0001) begin // no wrap on code drop
        next_s.rep_cnt = '0;
        next_s.meas_req = 1'b1;
      end
    end
    // user rate timer; held while self-test or hibernate runs
    if (s.st_active || s.hib || s.boot == asr_pkg::boot_wait) begin
      next_s.odr_cnt = '0;
    end else if (s.odr_cnt != '0) begin
      next_s.odr_cnt = s.odr_cnt - 32'h0000_0001;
    end else begin
      next_s.odr_cnt = (32'(ODR_BASE_CYC) << s.odr) - 32'h0000_0001;
      next_s.meas_req = 1'b1;
    end
    if (s.trig_sync[1] && !s.trig_prev && !s.hib) begin
      next_s.meas_req = 1'b1;
    end
    next_s.pwr = s.st_active ? `ASR_LPM : s.ctrl1[`ASR_CTRL1_PWR];
    // soft reset restores every default and reboots
    if (soft_rst) begin
      next_s = '0;
    end
  end

  // synchronous reset to all-zero defaults
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // pins and status outputs
  // ----------------------------------------
  // before the strap is caught, its synced level picks the drivers
  assign strap_now = (s.boot == asr_pkg::boot_wait) ? s.strap_sync[1]
                                                     : s.strap;
  assign boot_on = (s.boot == asr_pkg::boot_pulse);
  assign od = s.pin_sel[`ASR_PIN_OD];
  assign irq_pin_one_act = s.drdy | (boot_on & ~s.strap & ~s.boot_pulse_disable &
                    ~s.pin_sel[`ASR_PIN_BOOT2]);
  assign irq_pin_two_act = boot_on & ~s.strap & ~s.boot_pulse_disable &
                    s.pin_sel[`ASR_PIN_BOOT2];
  assign irq_pin_one_o = ~od & irq_pin_one_act;
  assign irq_pin_one_oe = ~od | irq_pin_one_act;
  assign irq_pin_two_o = ~strap_now & ~od & irq_pin_two_act;
  assign irq_pin_two_oe = strap_now ? boot_on
                                    : (~od | irq_pin_two_act);
  assign motion_detect_pin_o = 1'b0;
  assign motion_detect_pin_oe = strap_now & motion_event;
  assign meas_req = s.meas_req;
  assign selftest_active = s.st_active;
  assign power_mode = s.pwr;
  assign odr_code = s.odr;
  assign hibernate = s.hib;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  dec_write_a: assert property (
    wr_stb && addr == `ASR_A_SELFCHECK_SAMPLE_COUNT && !s.hib |=>
      s.selfcheck_sample_count == $past(wdata[3:0]))
    else $error("decimation field not written");
  dec_clamp_a: assert property (
    s.selfcheck_sample_count >= `ASR_SELFCHECK_SAMPLE_COUNT_MAX |-> rep_target == 13'h1000)
    else $error("decimation code not clamped");
  idle_len_a: assert property (
    s.st_active && s.unit_cnt == '0 && s.ctrl1[6:5] != 2'h0 && !s.hib
      |=> s.unit_cnt == $past(unit_len) - 20'h0_0001)
    else $error("idle phase length wrong");
  st_power_a: assert property (
    s.st_active |=> power_mode == `ASR_LPM && s.odr_cnt == '0)
    else $error("user settings used in self-test");
  st_exit_a: assert property (
    s.ctrl1[6:5] == 2'h0 |=> !selftest_active)
    else $error("self-test did not disengage");
  latch_flag_a: assert property (
    pop |=> s.drdy && s.out == $past(fifo_data[43:8]))
    else $error("sample and flag not together");
  lock_hold_a: assert property (
    busy && $past(busy) && !$past(soft_rst) |-> $stable(s.out)
      && $stable(s.bufd) && $stable(s.vm))
    else $error("outputs changed during transaction");
  drain_a: assert property (
    $fell(busy) && fifo_valid |-> pop)
    else $error("shadowed sample not moved out");
  trig_a: assert property (
    s.trig_sync[1] && !s.trig_prev && !s.hib |=> meas_req)
    else $error("trigger edge lost");
  boot_od_a: assert property (
    s.strap && boot_on |-> irq_pin_two_oe && !irq_pin_two_o)
    else $error("boot-done not pulled low");
endmodule // asr_ctrl
`default_nettype wire

// ---- asr_fifo.sv ----
// sample fifo between the sensing path and the output registers
`timescale 1ns/1ps
`default_nettype none
module asr_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } asr_fifo_s;
  asr_fifo_s s;
  asr_fifo_s next_s;
  logic push;
  logic pop;
  // honest flags straight from the occupancy count
  assign in_ready = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointers wrap at depth, so depth need not be a power of two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == AW'(DEPTH-1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH-1)) ? '0 : s.rd + AW'(1);
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // asr_fifo
`default_nettype wire

// ---- asr_host_model.sv ----
// spi host model driving the readout's register port
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
  input wire logic core_clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] rx [0:5];
  // link idles with clock low and chip select high
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // half link period: 4 core cycles gives the 80 ns sclk
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  // one frame: command byte then n data bytes, mode 0, msb first
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd,
                       input int n);
    logic [7:0] sh;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    for (int b = 0; b <= n; b++) begin
      sh = (b == 0) ? cmd : wd;
      for (int i = 7; i >= 0; i--) begin
        spi_mosi <= sh[i];
        half();
        spi_sclk <= 1'b1;
        // miso stands until the next fall, so the rise sees it settled
        if (b > 0) rx[b-1][i] = spi_miso;
        half();
        spi_sclk <= 1'b0;
      end
    end
    half();
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line must not keep a stale bit
    half();
  endtask
endmodule // asr_host_model
`default_nettype wire

// ---- asr_pkg.sv ----
// types shared by the readout control modules
`default_nettype none
package asr_pkg;
  typedef enum logic [1:0] {boot_wait, boot_pulse, boot_run} asr_boot_e;
  typedef enum logic [1:0] {spi_cmd, spi_wr, spi_rd} asr_spi_e;
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    asr_spi_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [6:0] addr;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
  } asr_spi_s;
  typedef struct packed {
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [1:0] strap_sync;
    logic strap;
    logic [1:0] mot_sync;
    logic mot_prev;
    logic busy_prev;
    asr_boot_e boot;
    logic [31:0] boot_cnt;
    logic drdy;
    logic [2:0][11:0] out;
    logic [7:0] temp;
    logic [2:0][11:0] bufd;
    logic [11:0] vm;
    logic [7:0] ctrl1;
    logic [3:0] odr;
    logic boot_pulse_disable;
    logic [1:0] pin_sel;
    logic [7:0] mot_cfg;
    logic [4:0] selfcheck_idle_len;
    logic [3:0] selfcheck_sample_count;
    logic hib;
    logic st_active;
    logic [19:0] unit_cnt;
    logic [12:0] rep_cnt;
    logic [31:0] odr_cnt;
    logic meas_req;
    logic [1:0] pwr;
  } asr_ctrl_s;
endpackage
`default_nettype wire

// ---- asr_regs.svh ----
// register map, field positions, reset values and timings of the readout
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ASR_A_STATUS 7'h00
`define ASR_A_OUT 7'h04
`define ASR_A_BUF 7'h0A
`define ASR_A_VM 7'h10
`define ASR_A_TEMP 7'h12
`define ASR_A_CTRL1 7'h15
`define ASR_A_ODR 7'h16
`define ASR_A_INT_EN 7'h20
`define ASR_A_PIN_SEL 7'h21
`define ASR_A_MOT_CFG 7'h30
`define ASR_A_SELFCHECK_IDLE_LEN 7'h37
`define ASR_A_SELFCHECK_SAMPLE_COUNT 7'h38
// ----------------------------------------
// fields and values
// ----------------------------------------
`define ASR_CTRL1_RST 7
`define ASR_CTRL1_AXIS 6:5
`define ASR_CTRL1_HIB 4
`define ASR_CTRL1_PWR 1:0
`define ASR_STAT_DRDY 7
`define ASR_STAT_BOOT 0
`define ASR_PIN_BOOT2 0
`define ASR_PIN_OD 1
`define ASR_SELFCHECK_SAMPLE_COUNT_MAX 4'hC
`define ASR_AXIS_OFF 2'h0
`define ASR_LPM 2'h0
`define ASR_MOT_DEFAULT 8'hC0
`define ASR_VM_MAX 12'h7FF
// ----------------------------------------
// timings
// ----------------------------------------
`define ASR_CLK_NS 10.0
`define ASR_ST_BASE_US 312.5
`define ASR_ST_STEP_US 31.25
`define ASR_ODR_BASE_US 312.5
`define ASR_BOOT_US 1000.0
`define ASR_PULSE1_US 10.0
`define ASR_PULSE2_MS 1.0
`endif

// ---- asr_spi_slave.sv ----
// spi register port: mode 0, command byte then auto-increment data bytes
`timescale 1ns/1ps
`default_nettype none
module asr_spi_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  output logic busy,
  output logic wr_stb,
  output logic rd_stb,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  asr_pkg::asr_spi_s s;
  asr_pkg::asr_spi_s next_s;
  logic rise;
  logic fall;
  // edges seen only after the two-stage synchronisers
  assign rise = s.sclk_sync[1] & ~s.sclk_sync[2];
  assign fall = ~s.sclk_sync[1] & s.sclk_sync[2];
  assign busy = ~s.cs_sync[1];
  assign spi_miso_oe = ~s.cs_sync[1];
  assign spi_miso_o = s.tx[7];
  assign wr_stb = s.wr_stb;
  assign rd_stb = s.rd_stb;
  assign addr = s.addr;
  assign wdata = s.wdata;
  // byte engine: sample on rising sclk, shift out on falling sclk
  always_comb begin
    next_s = s;
    next_s.sclk_sync = {s.sclk_sync[1:0], spi_sclk};
    next_s.cs_sync = {s.cs_sync[0], spi_cs_n};
    next_s.mosi_sync = {s.mosi_sync[0], spi_mosi};
    next_s.wr_stb = 1'b0;
    next_s.rd_stb = 1'b0;
    if (s.wr_stb | s.rd_stb) begin
      next_s.addr = s.addr + 7'h01;
    end
    if (s.cs_sync[1]) begin
      next_s.phase = asr_pkg::spi_cmd;
      next_s.bit_cnt = '0;
    end else if (rise) begin
      next_s.rx = {s.rx[6:0], s.mosi_sync[1]};
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      if (s.bit_cnt == 3'h7) begin
        unique case (s.phase)
          asr_pkg::spi_cmd: begin
            next_s.addr = {s.rx[5:0], s.mosi_sync[1]};
            next_s.phase = s.rx[6] ? asr_pkg::spi_rd : asr_pkg::spi_wr;
          end
          asr_pkg::spi_wr: begin
            next_s.wdata = {s.rx[6:0], s.mosi_sync[1]};
            next_s.wr_stb = 1'b1;
          end
          asr_pkg::spi_rd: begin
          end
        endcase
      end
    end else if (fall) begin
      // a read byte is fetched only when it is about to be shifted out
      if (s.bit_cnt == 3'h0 && s.phase == asr_pkg::spi_rd) begin
        next_s.tx = rdata;
        next_s.rd_stb = 1'b1;
      end else begin
        next_s.tx = {s.tx[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '{cs_sync: 2'h3, phase: asr_pkg::spi_cmd, default: '0};
    end else begin
      s <= next_s;
    end
  end
endmodule // asr_spi_slave
`default_nettype wire

// ---- tb_asr_ctrl.sv ----
// self-checking bench for the readout control block
`timescale 1ns/1ps
`default_nettype none
module tb_asr_ctrl;
  localparam int BOOT = 20;
  logic core_clk, rst_n, trig, strap, host_low, mot_ev, smp_valid;
  logic [43:0] smp_data;
  wire logic sclk, cs_n, mosi, miso_w, mot_w;
  logic miso_o, miso_oe, mot_o, mot_oe, i1_o, i1_oe, i2_o, i2_oe;
  logic smp_ready, meas_req, st_act, hib;
  logic [1:0] pmode;
  logic [3:0] odr;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  // released miso flips; motion line is open drain with a pull-up
  assign miso_w = miso_oe ? miso_o : ~miso_o;
  assign mot_w = !(mot_oe || host_low);
  asr_ctrl #(.BOOT_CYC(BOOT), .PULSE2_CYC(30), .ST_BASE_CYC(50),
    .ODR_BASE_CYC(40)) asr_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe), .external_sample_trigger(trig),
    .boot_config_pin(strap), .motion_detect_pin_i(mot_w),
    .motion_detect_pin_o(mot_o), .motion_detect_pin_oe(mot_oe),
    .motion_event(mot_ev), .irq_pin_one_o(i1_o), .irq_pin_one_oe(i1_oe),
    .irq_pin_two_o(i2_o), .irq_pin_two_oe(i2_oe), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .meas_req(meas_req),
    .selftest_active(st_act), .power_mode(pmode), .odr_code(odr),
    .hibernate(hib));
  asr_host_model asr_host_model_i (.core_clk(core_clk), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso_w));
  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // helpers: compare, wait, bus frames, byte views
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string m);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    asr_host_model_i.frame({1'b0, a}, d, 1);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    asr_host_model_i.frame({1'b1, a}, 8'h00, n);
  endtask
  function automatic logic [15:0] b(input int i);
    return {8'h00, asr_host_model_i.rx[i]};
  endfunction
  function automatic logic [15:0] pair(input int i);
    return {asr_host_model_i.rx[i+1], asr_host_model_i.rx[i]};
  endfunction
  task automatic push(input logic [43:0] d);
    clk(1);
    smp_valid <= 1'b1;
    smp_data <= d;
    clk(1);
    smp_valid <= 1'b0;
  endtask
  // cycles from one meas_req pulse to the next
  task automatic gap(output int g);
    g = 0;
    while (meas_req !== 1'b1 && g < 9000) begin
      clk(1);
      #1 g++;
    end
    g = 0;
    do begin
      clk(1);
      #1 g++;
    end while (meas_req !== 1'b1 && g < 9000);
  endtask
  task automatic t_regs();
    rd(7'h38, 1);
    check(b(0), 16'h0000, "dec reset");
    wr(7'h38, 8'hFD);
    rd(7'h38, 1);
    check(b(0), 16'h000D, "dec field");
  endtask
  task automatic t_selftest();
    int g;
    int dv[3] = '{1, 4, 0};
    int iv[3] = '{0, 0, 1};
    int ev[3] = '{100, 800, 3175};
    wr(7'h16, 8'h0F);
    for (int k = 0; k < 3; k++) begin
      wr(7'h37, 8'(iv[k]));
      wr(7'h38, 8'(dv[k]));
      if (k == 0) wr(7'h15, 8'h22);
      gap(g);
      gap(g);
      check(16'(g), 16'(ev[k]), "selftest period");
    end
    check(st_act, 16'h0001, "selftest on");
    check(pmode, 16'h0000, "power mode in selftest");
    wr(7'h15, 8'h02);
    clk(3);
    #1 check(st_act, 16'h0000, "selftest off");
    check(pmode, 16'h0002, "user power mode");
    check(odr, 16'h000F, "user rate");
  endtask
  task automatic t_trig();
    int k = 0;
    clk(10);
    trig <= 1'b1;
    do begin
      clk(1);
      #1 k++;
    end while (meas_req !== 1'b1 && k < 20);
    check(16'(k), 16'h0003, "trigger latency");
    clk(1);
    trig <= 1'b0;
  endtask
  task automatic t_lock();
    logic [43:0] sa = {12'h123, 12'h045, 12'h006, 8'h19};
    logic [43:0] sb = {12'h201, 12'h302, 12'hFFD, 8'h2A}; // negative z
    push(sa);
    clk(4);
    #1 check(i1_o, 16'h0001, "data-ready irq");
    check(smp_ready, 16'h0001, "fifo has room");
    rd(7'h00, 1);
    check(b(0) & 16'h0080, 16'h0080, "data-ready flag");
    // new sample lands while the frame holds the lock
    fork
      rd(7'h04, 6);
      begin
        clk(40);
        push(sb);
      end
    join
    check(pair(0), 16'h0123, "locked x");
    check(pair(4), 16'h0006, "locked z");
    rd(7'h04, 6);
    check(pair(2), 16'h0302, "shadowed y");
    rd(7'h0A, 6);
    check(pair(0), 16'h0123, "buffered x");
    rd(7'h10, 3);
    check(pair(0), 16'h0506, "magnitude");
    check(b(2), 16'h002A, "temperature");
  endtask
  task automatic t_hib();
    wr(7'h15, 8'h10);
    clk(3);
    #1 check(hib, 16'h0001, "hibernate set");
    rd(7'h00, 1);
    check(hib, 16'h0000, "cs wake");
  endtask
  task automatic t_soft();
    int k = 0;
    wr(7'h38, 8'h03);
    wr(7'h21, 8'h02);
    check(i1_oe, 16'h0000, "open-drain idle");
    wr(7'h15, 8'h80);
    while (i1_o !== 1'b1 && k < 200) begin
      clk(1);
      #1 k++;
    end
    check(i1_o, 16'h0001, "boot pulse");
    check(i1_oe, 16'h0001, "push-pull default");
    clk(1100);
    rd(7'h38, 1);
    check(b(0), 16'h0000, "soft reset");
  endtask
  task automatic t_strap();
    int k = 0;
    clk(1);
    strap <= 1'b1;
    rst_n <= 1'b0;
    clk(10);
    rst_n <= 1'b1;
    // pin two drives push-pull until the strap has passed its syncs
    clk(3);
    #1;
    while (i2_oe !== 1'b1 && k < 200) begin
      clk(1);
      #1 k++;
    end
    check(i2_o, 16'h0000, "boot-done low");
    k = 0;
    while (i2_oe === 1'b1 && k < 200) begin
      clk(1);
      #1 k++;
    end
    check(16'(k), 16'd30, "boot-done length");
    rd(7'h30, 1);
    check(b(0), 16'h00C0, "motion defaults");
    check(pmode, 16'h0000, "low-power kept");
    mot_ev <= 1'b1;
    clk(2);
    #1 check(mot_w, 16'h0000, "motion pulls low");
    check(mot_o, 16'h0000, "open drain");
    clk(1);
    mot_ev <= 1'b0;
    host_low <= 1'b1;
    clk(6);
    #1 check(hib, 16'h0001, "motion pin sleep");
    clk(1);
    host_low <= 1'b0;
    clk(6);
    #1 check(hib, 16'h0000, "motion pin wake");
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    trig = 1'b0;
    strap = 1'b0;
    host_low = 1'b0;
    mot_ev = 1'b0;
    smp_valid = 1'b0;
    smp_data = '0;
    clk(10);
    rst_n <= 1'b1;
    clk(BOOT + 5);
    t_regs();
    t_selftest();
    t_trig();
    t_lock();
    t_hib();
    t_soft();
    t_strap();
    summarize();
  end
  // hang guard well above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
endmodule // tb_asr_ctrl
`default_nettype wire
